/* common/config_chain_defs.svh */
`ifndef CONFIG_CHAIN_DEFS_SVH
`define CONFIG_CHAIN_DEFS_SVH

`define REG_W 64
`define ONCE_LEN 367
`define ONCE_USED 303
`define ONCE_CNT_W 9
`define MANY_LEN 36
`define ERR_LEN 60
`define STEP_BITS 6
`define SEL_DATA 1'h0
`define SEL_SHIFT 1'h1
`define SHIFT_GO_BIT 0
`define HOLD_RST 6'h00
`define MANY_RST 36'h000000000
`define ERR_RST 60'h000000000000000
`define ONCE_RST 367'h0

`endif

/* common/config_chain_pkg.sv */
`default_nettype none

`include "config_chain_defs.svh"

package config_chain_pkg;

   typedef enum logic [1:0] {
      ST_WAIT_BIST = 2'b00,
      ST_LOAD      = 2'b01,
      ST_DONE      = 2'b10
   } load_state_e;

   typedef struct packed {
      logic wr;
      logic rd;
      logic sel;
      logic [`REG_W-1:0] wdata;
   } priv_req_s;

   typedef struct packed {
      logic ack;
      logic [`REG_W-1:0] rdata;
   } priv_rsp_s;

   typedef logic [`STEP_BITS-1:0] step_t;

endpackage : config_chain_pkg

`default_nettype wire

/* rtl/shift_chain.sv */
`timescale 1ns/1ps
`default_nettype none

module shift_chain #(
   parameter int WIDTH = 36,
   parameter int STEP = 6
) (
   input wire logic clk_sys, // Core clock
   input wire logic rst_b, // Async reset, active low
   input wire logic shift_en, // Shift STEP bits in this cycle
   input wire logic [STEP-1:0] din, // Bits entering, MSB enters first
   output logic [WIDTH-1:0] q, // Chain contents
   output logic [STEP-1:0] dout // Bits leaving the far end
);

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         q <= '0;
         dout <= '0;
      end else if (shift_en) begin
         q <= {q[WIDTH-STEP-1:0], din};
         dout <= q[WIDTH-1:WIDTH-STEP];
      end
   end

endmodule : shift_chain

`default_nettype wire

/* rtl/config_shift_chains.sv */
`timescale 1ns/1ps
`default_nettype none

`include "config_chain_defs.svh"

// Function
// - After reset and self-test, load exactly 367 boot ROM bits, MSB first.
// - Reset-loaded chain holds 367 positions; 303 used; the first 64 bits loaded stay at the far end.
// - Writable chain is 36 bits; each retire after a data write shifts six bits in.
// - Error chain is 60 bits, read by alternating shift writes and data reads.
// - Each shift write with bit zero set destructively drops six bits from the error chain.
// - Data write holds six low bits; they shift in when the instruction retires.
// - Data read returns six bits, valid only after a shift access.
// - Writing one to shift bit zero moves six error bits into the data register.
module config_shift_chains
   import config_chain_pkg::*;
(
   input wire logic clk_sys, // Core clock, 10 MHz
   input wire logic rst_b, // Chip reset, active low
   input wire logic bist_done, // Self-test finished, level
   input wire logic serial_boot_rom_valid, // Boot ROM bit strobe
   input wire logic serial_boot_rom_bit, // Boot ROM serial data
   output logic serial_boot_rom_req, // Boot ROM load in progress
   output logic once_loaded, // Reset-loaded chain complete
   output logic [`ONCE_USED-1:0] once_cfg, // Used reset-loaded configuration
   output logic once_spill, // Bit leaving the reset-loaded chain
   output logic [`MANY_LEN-1:0] many_cfg, // Writable configuration chain
   input wire logic [`ERR_LEN-1:0] err_set, // Error capture bits, per-cycle
   input wire priv_req_s priv_req, // Privileged register access
   input wire logic priv_retire, // Pending data write retires
   output priv_rsp_s priv_rsp // Privileged read answer
);

   ////////////////////////////////////////////////////////////////////////////
   // Decode helpers

   function automatic logic hit_data(input priv_req_s r);
      hit_data = r.sel == `SEL_DATA;
   endfunction : hit_data

   function automatic logic shift_go(input priv_req_s r);
      shift_go = r.wr && r.sel == `SEL_SHIFT && r.wdata[`SHIFT_GO_BIT];
   endfunction : shift_go

   ////////////////////////////////////////////////////////////////////////////
   // Boot ROM load of the reset-loaded chain

   load_state_e state_reg;
   load_state_e state_next;
   logic [`ONCE_CNT_W-1:0] bit_cnt_reg;
   logic load_shift;
   logic [`ONCE_LEN-1:0] once_chain;
   logic once_out;

   assign load_shift = (state_reg == ST_LOAD) && serial_boot_rom_valid;

   always_comb begin
      state_next = state_reg;
      case (state_reg)
         ST_WAIT_BIST: begin
            if (bist_done) begin
               state_next = ST_LOAD;
            end
         end
         ST_LOAD: begin
            // Count is fixed; ROM content never shortens the load
            if (load_shift && bit_cnt_reg == `ONCE_CNT_W'(`ONCE_LEN - 1)) begin
               state_next = ST_DONE;
            end
         end
         ST_DONE: begin
            state_next = ST_DONE;
         end
         default: begin
            state_next = ST_WAIT_BIST;
         end
      endcase
   end

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         state_reg <= ST_WAIT_BIST;
      end else begin
         state_reg <= state_next;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         bit_cnt_reg <= '0;
      end else if (load_shift) begin
         bit_cnt_reg <= bit_cnt_reg + `ONCE_CNT_W'(1);
      end
   end

   // MSB arrives first and travels toward the far end
   shift_chain #(
      .WIDTH(`ONCE_LEN),
      .STEP(1)
   ) u_once_chain (
      .clk_sys(clk_sys),
      .rst_b(rst_b),
      .shift_en(load_shift),
      .din(serial_boot_rom_bit),
      .q(once_chain),
      .dout(once_out)
   );

   assign serial_boot_rom_req = state_reg == ST_LOAD;
   assign once_loaded = state_reg == ST_DONE;
   assign once_cfg = once_chain[`ONCE_USED-1:0];
   assign once_spill = once_out;

   ////////////////////////////////////////////////////////////////////////////
   // Writable chain, fed through the holding register

   step_t hold_reg;
   logic pend_reg;
   logic many_shift;
   logic [`MANY_LEN-1:0] many_chain;

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         hold_reg <= `HOLD_RST;
      end else if (priv_req.wr && hit_data(priv_req)) begin
         hold_reg <= priv_req.wdata[`STEP_BITS-1:0];
      end
   end

   // Write and retire in one cycle: the new write stays pending
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         pend_reg <= 1'b0;
      end else if (priv_req.wr && hit_data(priv_req)) begin
         pend_reg <= 1'b1;
      end else if (priv_retire) begin
         pend_reg <= 1'b0;
      end
   end

   assign many_shift = pend_reg && priv_retire;

   shift_chain #(
      .WIDTH(`MANY_LEN),
      .STEP(`STEP_BITS)
   ) u_many_chain (
      .clk_sys(clk_sys),
      .rst_b(rst_b),
      .shift_en(many_shift),
      .din(hold_reg),
      .q(many_chain),
      .dout()
   );

   assign many_cfg = many_chain;

   ////////////////////////////////////////////////////////////////////////////
   // Error chain and read side of the data register

   logic [`ERR_LEN-1:0] err_reg;
   logic [`ERR_LEN-1:0] err_next;
   step_t rd_data_reg;
   logic rd_ack_reg;
   logic [`REG_W-1:0] rdata_reg;

   // New errors are ORed after the shift so a capture is never lost
   always_comb begin
      err_next = err_reg;
      if (shift_go(priv_req)) begin
         err_next = {{`STEP_BITS{1'b0}}, err_reg[`ERR_LEN-1:`STEP_BITS]};
      end
      err_next = err_next | err_set;
   end

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         err_reg <= `ERR_RST;
      end else begin
         err_reg <= err_next;
      end
   end

   // Zero in bit zero leaves both data and chain untouched
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         rd_data_reg <= `HOLD_RST;
      end else if (shift_go(priv_req)) begin
         rd_data_reg <= err_reg[`STEP_BITS-1:0];
      end
   end

   // Read of the data register answers one cycle later
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         rd_ack_reg <= 1'b0;
         rdata_reg <= '0;
      end else begin
         rd_ack_reg <= priv_req.rd;
         if (priv_req.rd && hit_data(priv_req)) begin
            rdata_reg <= {{(`REG_W-`STEP_BITS){1'b0}}, rd_data_reg};
         end else if (priv_req.rd) begin
            rdata_reg <= '0;
         end
      end
   end

   assign priv_rsp.ack = rd_ack_reg;
   assign priv_rsp.rdata = rdata_reg;

endmodule : config_shift_chains

`default_nettype wire

/* verif/config_chk.sv */
`timescale 1ns/1ps
`default_nettype none
`include "config_chain_defs.svh"
module config_chk
   import config_chain_pkg::*;
(
   input wire logic clk_sys, // Clock
   input wire logic rst_b, // Reset
   input wire logic bist_done, // Self-test done
   input wire logic serial_boot_rom_valid, // Bit strobe
   input wire logic serial_boot_rom_bit, // Serial bit
   input wire logic serial_boot_rom_req, // Loading
   input wire logic once_loaded, // Loaded
   input wire logic [`ONCE_USED-1:0] once_cfg, // Reset-loaded chain
   input wire logic [`MANY_LEN-1:0] many_cfg, // Writable chain
   input wire priv_req_s priv_req, // Request
   input wire logic priv_retire, // Retire
   input wire priv_rsp_s priv_rsp // Answer
);
   logic [8:0] taken;
   default clocking @(posedge clk_sys);
   endclocking
   default disable iff (!rst_b);
   ////////////////////////////////////////////////////////////////
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         taken <= 9'h000;
      end else if (serial_boot_rom_req && serial_boot_rom_valid) begin
         taken <= taken + 9'h001;
      end
   end
   a_load_start: assert property (
      bist_done && !serial_boot_rom_req && !once_loaded |=> serial_boot_rom_req) else $error("load not started");
   a_load_count: assert property (
      $rose(once_loaded) |-> taken == 9'h16f) else $error("wrong boot bit count");
   a_load_shift: assert property (
      serial_boot_rom_req && serial_boot_rom_valid |=> once_cfg == 303'({$past(once_cfg), $past(serial_boot_rom_bit)}))
      else $error("boot bit not shifted in");
   a_many_hold: assert property (!priv_retire |=> $stable(many_cfg))
      else $error("chain moved without retire");
   a_many_shift: assert property (
      priv_req.wr && !priv_req.sel ##1 priv_retire && !priv_req.wr
      |=> many_cfg[5:0] == $past(priv_req.wdata[5:0], 2)) else $error("bad chain shift");
   a_ack_timing: assert property (priv_rsp.ack == $past(priv_req.rd))
      else $error("ack not one cycle after read");
   a_read_upper: assert property (priv_rsp.ack |-> priv_rsp.rdata[63:6] == 58'h0)
      else $error("reserved read bits set");
   a_shift_read: assert property (
      priv_req.rd && priv_req.sel |=> priv_rsp.rdata == 64'h0) else $error("strobe read");
   c_loaded: cover property ($rose(once_loaded));
   c_retire: cover property (priv_retire);
   c_ack: cover property (priv_rsp.ack);
endmodule : config_chk
`default_nettype wire

/* verif/boot_rom_model.sv */
`timescale 1ns/1ps
`default_nettype none
module boot_rom_model (
   input wire logic clk_sys, // Core clock
   input wire logic serial_boot_rom_req, // Load in progress
   input wire logic slow, // Idle every other cycle
   output logic serial_boot_rom_valid, // Bit strobe
   output logic serial_boot_rom_bit // Serial data
);
   logic [8:0] idx = 9'h000;
   logic gap = 1'b0;
   initial begin
      serial_boot_rom_valid = 1'b0;
      serial_boot_rom_bit = 1'b0;
   end
   always @(posedge clk_sys) begin
      if (serial_boot_rom_valid && serial_boot_rom_req) begin
         idx <= idx + 9'h001;
      end
      // Pacing taken at the edge, before the bench moves slow
      gap = slow && !gap;
      #1;
      serial_boot_rom_valid = serial_boot_rom_req && !gap;
      // Index zero is the first and most significant bit
      serial_boot_rom_bit = serial_boot_rom_valid ? ^(idx & 9'h025) : ~serial_boot_rom_bit;
   end
endmodule : boot_rom_model
`default_nettype wire

/* verif/tb.sv */
`timescale 1ns/1ps
`default_nettype none
`include "config_chain_defs.svh"
module tb;
   import config_chain_pkg::*;
   logic clk_sys = 1'b0;
   logic rst_b = 1'b0;
   logic bist_done = 1'b0;
   logic slow = 1'b1;
   logic priv_retire = 1'b0;
   logic serial_boot_rom_valid, serial_boot_rom_bit, serial_boot_rom_req, once_loaded, once_spill;
   logic [`ONCE_USED-1:0] once_cfg, exp_cfg;
   logic [`MANY_LEN-1:0] many_cfg, exp_many;
   logic [`ERR_LEN-1:0] err_set = '0;
   logic [`ERR_LEN-1:0] e60 = 60'h123456789abcdef;
   priv_req_s priv_req = '0;
   priv_rsp_s priv_rsp;
   int miscompares = 0;
   int checked = 0;
   int cyc = 0;
   int k;
   always #50 clk_sys = ~clk_sys;
   config_shift_chains dut (.clk_sys(clk_sys), .rst_b(rst_b), .bist_done(bist_done),
      .serial_boot_rom_valid(serial_boot_rom_valid), .serial_boot_rom_bit(serial_boot_rom_bit), .serial_boot_rom_req(serial_boot_rom_req),
      .once_loaded(once_loaded), .once_cfg(once_cfg), .once_spill(once_spill),
      .many_cfg(many_cfg), .err_set(err_set), .priv_req(priv_req),
      .priv_retire(priv_retire), .priv_rsp(priv_rsp));
   boot_rom_model rom (.clk_sys(clk_sys), .serial_boot_rom_req(serial_boot_rom_req), .slow(slow),
      .serial_boot_rom_valid(serial_boot_rom_valid), .serial_boot_rom_bit(serial_boot_rom_bit));
   ////////////////////////////////////////////////////////////////
   task automatic chk(input logic [`ONCE_USED-1:0] seen, exp);
      checked++;
      if (seen !== exp) begin
         miscompares++;
         $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
      end
   endtask : chk
   task automatic report_and_stop;
      $display("miscompares %0d checked %0d", miscompares, checked);
      if (miscompares == 0 && checked > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : report_and_stop
   // No clearing at the end, so back-to-back calls keep one write per step
   task automatic op(input logic w, r, s, input logic [63:0] d, input logic ret,
         input logic [63:0] ex);
      priv_req = {w, r, s, d};
      priv_retire = ret;
      @(posedge clk_sys) #1;
      if (r) begin
         chk(303'(priv_rsp.ack), 303'h1);
         chk(303'(priv_rsp.rdata), 303'(ex));
      end
   endtask : op
   always @(posedge clk_sys) begin
      cyc++;
      if (cyc == 4000) begin
         miscompares++;
         report_and_stop;
      end
   end
   ////////////////////////////////////////////////////////////////
   initial begin
      repeat (10) @(posedge clk_sys);
      #1 rst_b = 1'b1;
      repeat (5) @(posedge clk_sys) #1;
      chk(303'(serial_boot_rom_req), 303'h0);
      bist_done = 1'b1;
      for (k = 0; k < 1000 && !once_loaded; k++) begin
         slow = (k < 100);
         @(posedge clk_sys) #1;
      end
      chk(303'({once_loaded, serial_boot_rom_req}), 303'h2);
      for (k = 0; k < 303; k++) begin
         exp_cfg[k] = ^(9'(366 - k) & 9'h025);
      end
      chk(once_cfg, exp_cfg);
      chk(303'(once_spill), 303'h0);
      exp_many = '0;
      op(0, 0, 0, 64'h0, 1, 64'h0);
      for (k = 1; k <= 7; k++) begin
         op(1, 0, 0, {58'h2aaaaaaaaaaaaaa, 6'(k * 11)}, 0, 64'h0);
         chk(303'(many_cfg), 303'(exp_many));
         op(0, 0, 0, 64'h0, 1, 64'h0);
         exp_many = {exp_many[29:0], 6'(k * 11)};
         chk(303'(many_cfg), 303'(exp_many));
      end
      // Retire beside a new write shifts the older bits, the new one waits
      op(1, 0, 0, 64'h15, 0, 64'h0);
      op(1, 0, 0, 64'h2a, 1, 64'h0);
      exp_many = {exp_many[29:0], 6'h15};
      chk(303'(many_cfg), 303'(exp_many));
      op(0, 0, 0, 64'h0, 1, 64'h0);
      exp_many = {exp_many[29:0], 6'h2a};
      chk(303'(many_cfg), 303'(exp_many));
      err_set = e60;
      op(0, 1, 0, 64'h0, 0, 64'h0);
      err_set = '0;
      for (k = 0; k <= 10; k++) begin
         op(1, 0, 1, 64'h1, 0, 64'h0);
         op(1, 0, 1, 64'hfffffffffffffffe, 0, 64'h0);
         op(0, 1, 0, 64'h0, 0, (k < 10) ? 64'(e60[6 * k +: 6]) : 64'h0);
         op(0, 1, 1, 64'h0, 0, 64'h0);
      end
      op(0, 1, 1, 64'h0, 0, 64'h0);
      op(0, 0, 0, 64'h0, 0, 64'h0);
      report_and_stop;
   end
endmodule : tb
bind config_shift_chains config_chk chk_i (.*);
`default_nettype wire
